// ---- rtl/tct_pkg.sv ----
package tct_pkg;
    // word indices of the registers (byte address divided by four on the bus)
    localparam logic [3:0] ADDR_CNT1 = 4'h6;
    localparam logic [3:0] ADDR_CNT2 = 4'h7;
    localparam logic [3:0] ADDR_CNT3 = 4'h8;
    localparam logic [3:0] ADDR_CMD = 4'h9;
    localparam logic [3:0] ADDR_BANK = 4'ha;
    localparam int BUS_ADDR_W = 6;
    // command byte fields
    localparam int CMD_SEL_HI = 7;
    localparam int CMD_SEL_LO = 6;
    localparam int CMD_ACC_HI = 5;
    localparam int CMD_ACC_LO = 4;
    localparam int CMD_MODE_HI = 3;
    localparam int CMD_MODE_LO = 1;
    localparam int CMD_BCD = 0;
    localparam int RB_COUNT_N = 5;
    localparam int RB_STATUS_N = 4;
    localparam int RB_MASK_LO = 1;
    // status byte fields
    localparam int ST_OUT = 7;
    localparam int ST_NULL = 6;
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] ACC_LATCH = 2'h0;
    localparam logic [1:0] ACC_LOW = 2'h1;
    localparam logic [1:0] ACC_HIGH = 2'h2;
    localparam logic [1:0] ACC_BOTH = 2'h3;
    localparam logic [2:0] MODE_TC_INT = 3'h0;
    localparam logic [2:0] MODE_ONE_SHOT = 3'h1;
    localparam logic [2:0] MODE_RATE = 3'h2;
    localparam logic [2:0] MODE_SQUARE = 3'h3;
    localparam logic [2:0] MODE_SW_STROBE = 3'h4;
    localparam logic [2:0] MODE_HW_STROBE = 3'h5;
    // values after reset
    localparam logic [5:0] CFG_RESET = 6'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [7:0] READ_IDLE = 8'h00;
endpackage

// ---- rtl/tct_cmd_if.sv ----
`timescale 1ns/1ps
interface tct_cmd_if;
    logic cfgWrite;
    logic [5:0] cfgValue;
    logic dataWrite;
    logic dataRead;
    logic [7:0] wrData;
    logic countLatch;
    logic statusLatch;
    logic [7:0] rdData;
    modport ctl (output cfgWrite, cfgValue, dataWrite, dataRead, wrData,
        countLatch, statusLatch, input rdData);
    modport cnt (input cfgWrite, cfgValue, dataWrite, dataRead, wrData,
        countLatch, statusLatch, output rdData);
endinterface

// ---- rtl/tct_sync.sv ----
`timescale 1ns/1ps
module tct_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw pin and its filtered level
    input wire logic pinIn,
    output logic levelOut,
    output logic risePulse
);
    logic s1_r, s2_r, s3_r, primed_r;
    // stages carry no reset: a reset low on a pin idling high
    // would otherwise look like a rising edge just after reset
    always_ff @(posedge clk) begin
        s1_r <= pinIn;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            primed_r <= 1'b0;
            levelOut <= 1'b0;
            risePulse <= 1'b0;
        end else begin
            // change accepted only once the two later stages agree
            if (s2_r == s3_r) begin
                levelOut <= s3_r;
                primed_r <= 1'b1;
            end
            risePulse <= primed_r && (s2_r == s3_r) && s3_r && !levelOut;
        end
    end
endmodule

// ---- rtl/tct_counter.sv ----
`timescale 1ns/1ps
module tct_counter
    import tct_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register side
    tct_cmd_if.cnt cmd,
    // counting side, one-cycle pulses and a gate level
    input wire logic tick,
    input wire logic gate,
    input wire logic gateRise,
    output logic outLevel
);
    logic [5:0] cfg_r;
    logic [15:0] count_r, load_r, latch_r;
    logic [7:0] status_r;
    logic cntHeld_r, stHeld_r, nullCnt_r, wrHi_r, rdHi_r;
    logic armed_r, loadPend_r, trig_r;
    wire [1:0] acc = cfg_r[5:4];
    wire [2:0] mode = cfg_r[3:1];
    wire bcd = cfg_r[0];
    // modes 1 and 5 load their count on a gate edge only
    wire trigMode = (mode == MODE_ONE_SHOT) || (mode == MODE_HW_STROBE);
    wire [15:0] shown = cntHeld_r ? latch_r : count_r;

    function automatic logic [15:0] dec(input logic [15:0] v, input logic b);
        logic [15:0] r;
        r = v - 16'h0001;
        if (b) begin
            r = v;
            for (int i = 0; i < 4; i++) begin
                if (r[i*4 +: 4] != 4'h0) begin
                    r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                    break;
                end
                r[i*4 +: 4] = 4'h9;
            end
        end
        return r;
    endfunction

    // read data: status first, then latched or live count bytes
    always_comb begin
        if (stHeld_r) begin
            cmd.rdData = status_r;
        end else if (acc == ACC_HIGH || (acc == ACC_BOTH && rdHi_r)) begin
            cmd.rdData = shown[15:8];
        end else begin
            cmd.rdData = shown[7:0];
        end
    end

    wire wrDone = cmd.dataWrite && (acc != ACC_BOTH || wrHi_r);
    wire [15:0] newLoad = (acc == ACC_LOW) ? {8'h00, cmd.wrData} :
        (acc == ACC_HIGH) ? {cmd.wrData, 8'h00} :
        (wrHi_r ? {cmd.wrData, load_r[7:0]} : {8'h00, cmd.wrData});
    // a zero count stands for the full range
    wire reload = loadPend_r || (trig_r && (mode == MODE_ONE_SHOT ||
        mode == MODE_HW_STROBE));
    wire [15:0] stepped = dec(count_r, bcd);
    wire atOne = (count_r == 16'h0001);
    wire atTwo = (count_r == 16'h0002);
    wire gateOk = gate || mode == MODE_ONE_SHOT || mode == MODE_HW_STROBE;

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_r <= CFG_RESET;
            count_r <= COUNT_RESET;
            load_r <= COUNT_RESET;
            latch_r <= COUNT_RESET;
            status_r <= READ_IDLE;
            {cntHeld_r, stHeld_r, nullCnt_r} <= 3'h0;
            {wrHi_r, rdHi_r, armed_r, loadPend_r, trig_r} <= 5'h00;
            outLevel <= 1'b0;
        end else begin
            if (cmd.cfgWrite) begin
                cfg_r <= cmd.cfgValue;
                trig_r <= 1'b0;
                {cntHeld_r, stHeld_r, wrHi_r, rdHi_r} <= 4'h0;
                armed_r <= 1'b0;
                nullCnt_r <= 1'b1;
                outLevel <= (cmd.cfgValue[3:1] != MODE_TC_INT);
            end
            if (cmd.dataWrite) begin // [RULE_04]
                load_r <= newLoad;
                wrHi_r <= (acc == ACC_BOTH) && !wrHi_r;
                if (wrDone) begin
                    nullCnt_r <= 1'b1; // [RULE_20]
                    loadPend_r <= !trigMode;
                    if (mode == MODE_TC_INT) begin
                        outLevel <= 1'b0;
                    end
                    armed_r <= 1'b1;
                end
            end
            if (cmd.dataRead) begin // [RULE_05]
                if (stHeld_r) begin
                    stHeld_r <= 1'b0; // [RULE_08]
                end else if (acc == ACC_BOTH && !rdHi_r) begin
                    rdHi_r <= 1'b1; // [RULE_07]
                end else begin
                    rdHi_r <= 1'b0;
                    cntHeld_r <= 1'b0;
                end
            end
            if (cmd.countLatch && !cntHeld_r) begin // [RULE_06]
                latch_r <= count_r; // [RULE_11]
                cntHeld_r <= 1'b1;
            end
            if (cmd.statusLatch && !stHeld_r) begin // [RULE_06]
                status_r <= {outLevel, nullCnt_r, cfg_r}; // [RULE_19]
                stHeld_r <= 1'b1;
            end
            // a command word written in the same cycle wins over the tick
            if (tick && armed_r && !cmd.cfgWrite) begin // [RULE_21]
                if (reload) begin
                    count_r <= load_r;
                    if (!wrDone) begin
                        // a count written in this cycle stays pending
                        nullCnt_r <= 1'b0; // [RULE_20]
                        loadPend_r <= 1'b0;
                    end
                    trig_r <= 1'b0;
                    if (mode == MODE_ONE_SHOT) begin
                        outLevel <= 1'b0;
                    end
                end else if (gateOk) begin
                    count_r <= stepped;
                    case (mode)
                        MODE_TC_INT, MODE_ONE_SHOT: begin
                            if (atOne) begin
                                outLevel <= 1'b1;
                            end
                        end
                        MODE_RATE: begin
                            outLevel <= !atTwo;
                            if (atOne) begin
                                count_r <= load_r;
                            end
                        end
                        MODE_SQUARE: begin
                            if (atOne) begin
                                outLevel <= !outLevel;
                                count_r <= load_r;
                            end
                        end
                        MODE_SW_STROBE, MODE_HW_STROBE: begin
                            outLevel <= !atOne;
                        end
                        default: begin
                            outLevel <= outLevel;
                        end
                    endcase
                end
            end
            // a gate edge wins over any clear of the trigger in this cycle
            if (gateRise) begin
                trig_r <= 1'b1;
            end
        end
    end
endmodule

// ---- rtl/tct_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] three counters; first two make wave events, third can clock them
// [RULE_02] data ports at 06, 07 with bank bit clear, and 08
// [RULE_03] command register is write-only at 09
// [RULE_04] data write loads starting count in the chosen byte order
// [RULE_05] reads give live count unless latched data waits unread
// [RULE_06] latch requests ignored while earlier latched data is unread
// [RULE_07] latched 16-bit count reads low byte first, then high
// [RULE_08] status byte reads first, then count bytes
// [RULE_09] select field 00,01,10 picks counter; 11 means read-back
// [RULE_10] access field: latch, low only, high only, low then high
// [RULE_11] count-latch captures selected counter's count for next read
// [RULE_12] mode field picks one of six counting modes
// [RULE_13] bit 0 set counts in decimal, clear counts in binary
// [RULE_14] read-back latches count, status or both of several counters
// [RULE_15] read-back bit 5 low latches counts of named counters
// [RULE_16] read-back bit 4 low latches status of named counters
// [RULE_17] read-back bits 3..1 name third, second and first counter
// [RULE_18] software writes zero in bit 0 of a read-back command
// [RULE_19] status byte: output, null count, access, mode, decimal bit
// [RULE_20] null count is one until the written count is loaded
// [RULE_21] counters step on clock edges and drive outputs per mode
module tct_top
    import tct_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [BUS_ADDR_W-1:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    // counter pins from outside
    input wire logic [2:0] cntClkPin,
    input wire logic [2:0] cntGatePin,
    // counter outputs
    output logic [2:0] cntOut
);
    logic bank_r, done_r;
    logic [31:0] rdData_r;
    logic [2:0] outQ_r;
    logic [2:0] clkRise, gateLvl, gateRise, outW;
    logic [2:0] tick;
    logic [7:0] rdByte [3];

    tct_cmd_if ch [3] ();

    // word index taken from the byte address
    wire [3:0] idx = avsAddress[5:2];
    wire access = (avsRead || avsWrite) && !done_r;
    wire lane0 = avsByteEnable[0];
    wire hitC1 = (idx == ADDR_CNT1) && !bank_r; // [RULE_02]
    wire hitC2 = (idx == ADDR_CNT2) && !bank_r; // [RULE_02]
    wire hitC3 = (idx == ADDR_CNT3); // [RULE_02]
    wire hitCmd = (idx == ADDR_CMD); // [RULE_03]
    wire hitBank = (idx == ADDR_BANK);
    wire [2:0] hitCnt = {hitC3, hitC2, hitC1};
    wire [7:0] wb = avsWriteData[7:0];
    wire cmdWr = access && avsWrite && lane0 && hitCmd;
    wire [1:0] pick = wb[CMD_SEL_HI:CMD_SEL_LO]; // [RULE_09]
    wire [1:0] accSel = wb[CMD_ACC_HI:CMD_ACC_LO]; // [RULE_10]
    wire isRb = (pick == SEL_READBACK); // [RULE_14]
    // bit 0 of a read-back is not checked; software keeps it zero
    wire [2:0] rbMask = wb[RB_MASK_LO +: 3]; // [RULE_17] [RULE_18]

    function automatic logic [2:0] onehot(input logic [1:0] p);
        return (p == 2'h0) ? 3'h1 : (p == 2'h1) ? 3'h2 :
            (p == 2'h2) ? 3'h4 : 3'h0;
    endfunction

    wire [2:0] picked = onehot(pick);
    // counter three can replace the pin clock of the first two
    logic [1:0] useC3_r;

    generate
        for (genvar i = 0; i < 3; i++) begin : g_cnt
            tct_sync u_clk (
                .clk(clk),
                .rst(rst),
                .pinIn(cntClkPin[i]),
                .levelOut(),
                .risePulse(clkRise[i])
            );
            tct_sync u_gate (
                .clk(clk),
                .rst(rst),
                .pinIn(cntGatePin[i]),
                .levelOut(gateLvl[i]),
                .risePulse(gateRise[i])
            );
            // mode and format kept per counter [RULE_12] [RULE_13]
            assign ch[i].cfgWrite = cmdWr && !isRb && picked[i] &&
                accSel != ACC_LATCH;
            assign ch[i].cfgValue = wb[5:0];
            assign ch[i].dataWrite = access && avsWrite && lane0 &&
                hitCnt[i];
            assign ch[i].dataRead = access && avsRead && hitCnt[i];
            assign ch[i].wrData = wb;
            assign ch[i].countLatch = cmdWr && ((!isRb && picked[i] &&
                accSel == ACC_LATCH) || // [RULE_11]
                (isRb && rbMask[i] && !wb[RB_COUNT_N])); // [RULE_15]
            assign ch[i].statusLatch = cmdWr && isRb && rbMask[i] &&
                !wb[RB_STATUS_N]; // [RULE_16]
            assign rdByte[i] = ch[i].rdData;
            tct_counter u_cnt (
                .clk(clk),
                .rst(rst),
                .cmd(ch[i]),
                .tick(tick[i]),
                .gate(gateLvl[i]),
                .gateRise(gateRise[i]),
                .outLevel(outW[i])
            );
        end
    endgenerate

    // third counter output rising edge feeds the first two on request
    wire c3Rise = outW[2] && !outQ_r[2]; // [RULE_01]
    assign tick[0] = useC3_r[0] ? c3Rise : clkRise[0];
    assign tick[1] = useC3_r[1] ? c3Rise : clkRise[1];
    assign tick[2] = clkRise[2];

    wire [7:0] rdSel = hitC1 ? rdByte[0] : hitC2 ? rdByte[1] :
        hitC3 ? rdByte[2] : hitBank ? {5'h00, useC3_r, bank_r} : READ_IDLE;

    // one wait cycle per access keeps the read pops exactly once
    assign avsWaitRequest = (avsRead || avsWrite) && !done_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            done_r <= 1'b0;
            rdData_r <= 32'h00000000;
            bank_r <= 1'b0;
            useC3_r <= 2'h0;
            outQ_r <= 3'h0;
            cntOut <= 3'h0;
        end else begin
            done_r <= access;
            outQ_r <= outW;
            cntOut <= outW; // [RULE_21]
            if (access && avsRead) begin
                rdData_r <= {24'h000000, rdSel};
            end
            if (access && avsWrite && lane0 && hitBank) begin
                bank_r <= wb[0];
                useC3_r <= wb[2:1];
            end
        end
    end
    assign avsReadData = rdData_r;
endmodule

// ---- sim/tct_top_chk.sv ----
`timescale 1ns/1ps
module tct_top_chk
    import tct_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [BUS_ADDR_W-1:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    input wire logic [31:0] avsReadData,
    input wire logic avsWaitRequest,
    // counter pins
    input wire logic [2:0] cntClkPin,
    input wire logic [2:0] cntGatePin,
    input wire logic [2:0] cntOut
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire req = avsRead | avsWrite;
    wire [3:0] word = avsAddress[BUS_ADDR_W-1:2];
    wire mapped = (word >= ADDR_CNT1) && (word <= ADDR_BANK);
    wire doneRd = avsRead & ~avsWaitRequest;
    wire bankWr = avsWrite & ~avsWaitRequest & (word == ADDR_BANK);
    wire hidden = (word == ADDR_CNT1) || (word == ADDR_CNT2);
    logic bankSel_r;
    logic bankSel_nxt;
    // mirror of the bank bit so reads of hidden ports can be judged
    assign bankSel_nxt = (bankWr & avsByteEnable[0]) ? avsWriteData[0]
        : bankSel_r;
    always_ff @(posedge clk) begin
        bankSel_r <= rst ? 1'b0 : bankSel_nxt;
    end
    sequence s_reqOpen;
        req && avsWaitRequest;
    endsequence
    sequence s_reqDone;
        req && !avsWaitRequest;
    endsequence
    a_wait_first: assert property ($rose(req) |-> s_reqOpen)
        else $error("no wait state on new request");
    a_wait_single: assert property (s_reqOpen |=> s_reqDone)
        else $error("wait state longer than one cycle");
    a_wait_idle: assert property (!req |-> !avsWaitRequest)
        else $error("wait asserted with no request");
    a_upper_zero: assert property (doneRd |-> avsReadData[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    a_cmd_hidden: assert property (
        doneRd && word == ADDR_CMD |-> avsReadData == 32'h0)
        else $error("command register readable");
    a_unmapped_zero: assert property (
        doneRd && !mapped |-> avsReadData == 32'h0)
        else $error("unmapped read not zero");
    a_bank_hides: assert property (
        doneRd && bankSel_r && hidden |-> avsReadData == 32'h0)
        else $error("counter port visible with bank bit set");
    a_read_holds: assert property (
        !avsRead |=> $stable(avsReadData))
        else $error("read data changed without a read");
    a_reset_quiet: assert property (
        $fell(rst) |-> cntOut == 3'h0 && avsReadData == 32'h0)
        else $error("outputs not cleared by reset");
endmodule

// ---- sim/tct_pin_src.sv ----
`timescale 1ns/1ps
module tct_pin_src (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // burst request
    input wire logic start,
    input wire logic [1:0] sel,
    input wire logic [7:0] num,
    output logic busy,
    // counter clock pins, idle low between bursts
    output logic [2:0] pin
);
    logic [7:0] left_r;
    logic [2:0] phase_r;
    logic [1:0] pick_r;
    assign busy = (left_r != 8'h00);
    // slow 8-cycle pulses so the 3-flop synchroniser sees every edge
    assign pin = (busy && phase_r[2]) ? (3'h1 << pick_r) : 3'h0;
    always_ff @(posedge clk) begin
        if (rst) begin
            left_r <= 8'h00;
            phase_r <= 3'h0;
            pick_r <= 2'h0;
        end else if (start && !busy) begin
            left_r <= num;
            phase_r <= 3'h0;
            pick_r <= sel;
        end else if (busy) begin
            phase_r <= phase_r + 3'h1;
            left_r <= (phase_r == 3'h7) ? left_r - 8'h01 : left_r;
        end
    end
endmodule

// ---- sim/tct_top_test.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin fails++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tct_top_test;
    import tct_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [BUS_ADDR_W-1:0] avsAddress = '0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic [31:0] avsReadData;
    logic avsWaitRequest;
    logic [2:0] cntClkPin;
    logic [2:0] cntOut;
    logic [2:0] gatePin = 3'h7;
    logic srcStart = 1'b0;
    logic [1:0] srcSel = 2'h0;
    logic [7:0] srcNum = 8'h00;
    logic srcBusy;
    logic [7:0] q;
    int fails = 0;
    int checkCount = 0;
    int cycles = 0;
    always #10 clk = ~clk;
    tct_top tct_top_inst (.clk(clk), .rst(rst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(4'h1), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .cntClkPin(cntClkPin),
        .cntGatePin(gatePin), .cntOut(cntOut));
    tct_pin_src tct_pin_src_inst (.clk(clk), .rst(rst), .start(srcStart),
        .sel(srcSel), .num(srcNum), .busy(srcBusy), .pin(cntClkPin));
    task final_report;
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // a hung handshake ends the run here rather than never
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            final_report();
        end
    end
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        avsAddress <= {a, 2'b00};
        avsWrite <= w;
        avsRead <= ~w;
        avsWriteData <= {24'h0, d};
        do @(posedge clk); while (avsWaitRequest !== 1'b0);
        q = avsReadData[7:0];
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(q, e)
    endtask
    task pulses(input logic [1:0] s, input logic [7:0] n);
        @(posedge clk);
        srcStart <= 1'b1;
        srcSel <= s;
        srcNum <= n;
        @(posedge clk);
        srcStart <= 1'b0;
        do @(posedge clk); while (srcBusy === 1'b1);
        repeat (8) @(posedge clk);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wr(ADDR_CMD, 8'h34);
        wr(ADDR_CNT1, 8'h34);
        wr(ADDR_CNT1, 8'h12);
        wr(ADDR_CMD, 8'he2);
        rd(ADDR_CNT1, 8'hf4);
        $display("test status before load done");
        pulses(2'h0, 8'd5);
        `CHK(cntOut[0], 1'b1)
        wr(ADDR_CMD, 8'hc2);
        rd(ADDR_CNT1, 8'hb4);
        rd(ADDR_CNT1, 8'h30);
        rd(ADDR_CNT1, 8'h12);
        $display("test status and count latch done");
        wr(ADDR_CMD, 8'h00);
        pulses(2'h0, 8'd3);
        wr(ADDR_CMD, 8'h00);
        wr(ADDR_CMD, 8'hd2);
        rd(ADDR_CNT1, 8'h30);
        rd(ADDR_CNT1, 8'h12);
        rd(ADDR_CNT1, 8'h2d);
        rd(ADDR_CNT1, 8'h12);
        $display("test repeated latch done");
        // decimal count across a digit borrow
        wr(ADDR_CMD, 8'h91);
        wr(ADDR_CNT3, 8'h20);
        wr(ADDR_CMD, 8'he8);
        rd(ADDR_CNT3, 8'h51);
        pulses(2'h2, 8'd3);
        `CHK(cntOut[2], 1'b0)
        wr(ADDR_CMD, 8'h80);
        rd(ADDR_CNT3, 8'h18);
        $display("test decimal counter three done");
        for (int m = 0; m < 6; m++) begin
            wr(ADDR_CMD, {2'b01, ACC_LOW, m[2:0], 1'b0});
            wr(ADDR_CMD, 8'he4);
            bus(1'b0, ADDR_CNT2, 8'h00);
            `CHK(q & 8'h7f, {2'b01, ACC_LOW, m[2:0], 1'b0})
        end
        wr(ADDR_CMD, 8'h60);
        wr(ADDR_CNT2, 8'h40);
        pulses(2'h1, 8'd2);
        wr(ADDR_CMD, 8'h40);
        rd(ADDR_CNT2, 8'h3f);
        $display("test modes and high byte done");
        wr(ADDR_BANK, 8'h01);
        rd(ADDR_CNT1, 8'h00);
        rd(ADDR_CNT2, 8'h00);
        wr(ADDR_BANK, 8'h00);
        rd(ADDR_CNT2, 8'h3f);
        rd(ADDR_CMD, 8'h00);
        rd(4'hf, 8'h00);
        $display("test decode done");
        wr(ADDR_CMD, 8'h12);
        wr(ADDR_CNT1, 8'h02);
        pulses(2'h0, 8'd1);
        `CHK(cntOut[0], 1'b1)
        gatePin <= 3'h6;
        repeat (6) @(posedge clk);
        gatePin <= 3'h7;
        repeat (6) @(posedge clk);
        pulses(2'h0, 8'd2);
        `CHK(cntOut[0], 1'b0)
        pulses(2'h0, 8'd1);
        `CHK(cntOut[0], 1'b1)
        $display("test gate triggered one-shot done");
        wr(ADDR_CMD, 8'h94);
        wr(ADDR_CNT3, 8'h02);
        wr(ADDR_CMD, 8'h50);
        wr(ADDR_CNT2, 8'h03);
        wr(ADDR_BANK, 8'h04);
        rd(ADDR_BANK, 8'h04);
        pulses(2'h2, 8'd8);
        `CHK(cntOut[1], 1'b0)
        pulses(2'h2, 8'd1);
        `CHK(cntOut[1], 1'b1)
        `CHK(cntOut[2], 1'b1)
        $display("test counter three as clock done");
        final_report();
    end
endmodule
bind tct_top tct_top_chk tct_top_chk_inst (.clk(clk), .rst(rst),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .cntClkPin(cntClkPin), .cntGatePin(cntGatePin), .cntOut(cntOut));
